//--- design/mmd_pkg.sv
// How it works
// - rom words 0 to $000F form the vector area with eight fixed entry points.
// - zero-page calls may target any rom word from 0 to $003F.
// - table move fetches an 8-bit pattern from rom words 0 to $0FFF.
// - the pattern goes to port 1/port 2 data registers or accumulator/B pair.
// - every implemented rom word, 0 to capacity minus one, is program memory.
// - program words are 10 bits wide, data digits are 4 bits wide.
// - data addresses 0 to $03F map onto hardware registers, not storage.
// - $000-$003 control bits, $004-$01F and $024-$03F special, $020-$023 flags.
// - control bits are reached only by bit set, clear and test operations.
// - bit set writes 1, bit clear writes 0, bit test reports the value.
// - $000 holds ext0 mask, ext0 request, stack clear, global enable.
// - $002 holds timer c mask, timer c request, timer b mask, timer b request.
// - $003 holds serial mask, serial request, adc mask, adc request.
// - some control bits accept only part of the set, clear and test operations.
// - bit set on a request flag or stack clear is ignored; no stack clear test.
package mmd_pkg;
  localparam int ROM_AW = 14;
  localparam int RAM_AW = 10;
  localparam int WORD_W = 10;
  localparam int DIGIT_W = 4;
  localparam logic [ROM_AW-1:0] VECTOR_TOP = 14'h000f;
  localparam logic [ROM_AW-1:0] ZPAGE_TOP = 14'h003f;
  localparam logic [ROM_AW-1:0] PATTERN_TOP = 14'h0fff;
  localparam logic [RAM_AW-1:0] REGAREA_TOP = 10'h03f;
  localparam logic [RAM_AW-1:0] CTRL_TOP = 10'h003;
  localparam logic [RAM_AW-1:0] FLAG_LO = 10'h020;
  localparam logic [RAM_AW-1:0] FLAG_HI = 10'h023;
  localparam logic [RAM_AW-1:0] IRQ_CTRL_EXT0_ENABLE = 10'h000;
  localparam logic [RAM_AW-1:0] IRQ_CTRL_TIMERS_B_C = 10'h002;
  localparam logic [RAM_AW-1:0] IRQ_CTRL_SERIAL_ADC = 10'h003;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  // bit positions: mask 3, request 2, mask 1, request 0; in $000 bit 1 is stack clear, bit 0 global enable
  localparam int POS_MASK_HI = 3;
  localparam int POS_REQ_HI = 2;
  localparam int POS_MASK_LO = 1;
  localparam int POS_REQ_LO = 0;
  localparam int POS_SP_CLEAR = 1;
  localparam int POS_GIE = 0;
  typedef enum logic [2:0] {
    MMD_OP_NONE = 3'h0,
    MMD_OP_SET = 3'h1,
    MMD_OP_CLEAR = 3'h2,
    MMD_OP_TEST = 3'h3,
    MMD_OP_OTHER = 3'h4
  } mmd_bitop_t;
  typedef enum logic [1:0] {
    MMD_DEST_PORTS = 2'h0,
    MMD_DEST_ACC_B = 2'h1
  } mmd_dest_t;
endpackage

//--- design/mmd_rom_decode.sv
`timescale 1ns/1ns
module mmd_rom_decode #(
  parameter int CAPACITY = 16384
) (
  input wire logic [mmd_pkg::ROM_AW-1:0] romAddr,
  output logic inVector,
  output logic inZeroPage,
  output logic inPattern,
  output logic inProgram,
  output logic [2:0] vectorSlot
);
  // refuse capacities outside the smallest and largest rom
  if (CAPACITY < 1024 || CAPACITY > 16384) begin : g_cap_check
    $error("capacity out of range");
  end
  localparam logic [mmd_pkg::ROM_AW:0] CAP_W = (mmd_pkg::ROM_AW+1)'(CAPACITY);
  // window decode of one rom address
  assign inVector = romAddr <= mmd_pkg::VECTOR_TOP;
  assign inZeroPage = romAddr <= mmd_pkg::ZPAGE_TOP;
  assign inPattern = romAddr <= mmd_pkg::PATTERN_TOP && {1'b0, romAddr} < CAP_W;
  assign inProgram = {1'b0, romAddr} < CAP_W;
  assign vectorSlot = romAddr[3:1]; // two-word jumps, eight entries
endmodule

//--- design/mmd_memory_map.sv
`timescale 1ns/1ns
module mmd_memory_map #(
  parameter int CAPACITY = 16384
) (
  input wire logic ref_clk,
  input wire logic rst,
  // fetch side
  input wire logic [mmd_pkg::ROM_AW-1:0] romAddr,
  input wire logic fetchValid,
  input wire logic isZeroPageCall,
  input wire logic isTableMove,
  input wire logic tableDestAccB,
  input wire logic [mmd_pkg::WORD_W-1:0] romData,
  input wire logic [2:0] vectorCause,
  input wire logic vectorTake,
  output logic romFault,
  output logic vectorRegion,
  output logic [mmd_pkg::ROM_AW-1:0] vectorAddr,
  output logic [7:0] patternData,
  output logic patternToPorts,
  output logic patternToAccB,
  // data side
  input wire logic [mmd_pkg::RAM_AW-1:0] ramAddr,
  input wire logic [2:0] bitOp,
  input wire logic [1:0] bitSel,
  output logic selCtrl,
  output logic selSpecial,
  output logic selFlag,
  output logic selStorage,
  output logic testBit,
  output logic testValid,
  // event sources
  input wire logic ext0Event,
  input wire logic timerBEvent,
  input wire logic timerCEvent,
  input wire logic serialEvent,
  input wire logic adcEvent,
  output logic stackPointerClear,
  output logic irqRequest,
  output logic [3:0] ctrl0,
  output logic [3:0] ctrl2,
  output logic [3:0] ctrl3
);
  logic inVector;
  logic inZeroPage;
  logic inPattern;
  logic inProgram;
  logic regArea;
  logic isCtrl;
  logic setOp;
  logic clrOp;
  logic tstOp;
  logic [3:0] hit;
  logic [3:0] setMask;
  logic [3:0] clrMask;
  logic [3:0] ev0;
  logic [3:0] ev2;
  logic [3:0] ev3;
  logic [3:0] nibble;
  logic [3:0] allowSet;

  // the window decode only serves capacities from 1k to 16k words
  if (CAPACITY < 1024 || CAPACITY > 16384) begin : g_cap_check
    $error("capacity out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // rom windows
  mmd_rom_decode #(
    .CAPACITY(CAPACITY)
  ) u_rom (
    .romAddr(romAddr),
    .inVector(inVector),
    .inZeroPage(inZeroPage),
    .inPattern(inPattern),
    .inProgram(inProgram),
    .vectorSlot() // the entry is chosen by the cause, not read back here
  );

  // illegal fetch, call target or table address flagged
  // a fault pulse lets the core trap a stray fetch instead of running on
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      romFault <= 1'b0;
      vectorRegion <= 1'b0;
    end else begin
      romFault <= fetchValid && (!inProgram ||
        (isZeroPageCall && !inZeroPage) ||
        (isTableMove && !inPattern));
      vectorRegion <= fetchValid && inVector;
    end
  end

  // one of eight fixed entries chosen by the cause
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      vectorAddr <= '0; // reset entry
    end else if (vectorTake) begin
      vectorAddr <= {(mmd_pkg::ROM_AW-4)'(0), vectorCause, 1'b0};
    end
  end

  // 8-bit pattern from the low byte of a 10-bit word, routed to a pair
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      patternData <= 8'h00;
      patternToPorts <= 1'b0;
      patternToAccB <= 1'b0;
    end else begin
      patternToPorts <= fetchValid && isTableMove && inPattern && !tableDestAccB;
      patternToAccB <= fetchValid && isTableMove && inPattern && tableDestAccB;
      if (fetchValid && isTableMove && inPattern) begin
        patternData <= romData[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // data address decode
  // the four windows are exclusive and together cover the whole data space
  assign regArea = ramAddr <= mmd_pkg::REGAREA_TOP;
  assign isCtrl = ramAddr <= mmd_pkg::CTRL_TOP;
  assign selCtrl = isCtrl;
  assign selFlag = ramAddr >= mmd_pkg::FLAG_LO && ramAddr <= mmd_pkg::FLAG_HI;
  assign selSpecial = regArea && !isCtrl && !selFlag;
  assign selStorage = !regArea;

  // only bit operations reach control bits
  assign setOp = isCtrl && bitOp == 3'(mmd_pkg::MMD_OP_SET);
  assign clrOp = isCtrl && bitOp == 3'(mmd_pkg::MMD_OP_CLEAR);
  assign tstOp = isCtrl && bitOp == 3'(mmd_pkg::MMD_OP_TEST);
  // one-hot select of the addressed bit
  assign hit = 4'h1 << bitSel;
  // set allowed only on masks and global enable
  assign allowSet = ramAddr[1:0] == 2'h0 ? 4'h9 : 4'ha;
  assign setMask = setOp ? (hit & allowSet) : 4'h0;
  assign clrMask = clrOp ? hit : 4'h0;

  // hardware events set request flags; set wins over clear
  // an event meeting a software clear in one cycle leaves the flag set
  assign ev0 = {1'b0, ext0Event, 2'b00};
  assign ev2 = {1'b0, timerCEvent, 1'b0, timerBEvent};
  assign ev3 = {1'b0, serialEvent, 1'b0, adcEvent};

  // control nibble $000
  // the stack clear bit is never stored; it only acts as a strobe
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl0 <= mmd_pkg::CTRL_RESET;
    end else if (ramAddr[1:0] == 2'h0) begin
      ctrl0 <= ((ctrl0 | setMask) & ~clrMask & 4'hd) | ev0;
    end else begin
      ctrl0 <= (ctrl0 & 4'hd) | ev0;
    end
  end

  // stack pointer clear is a one-cycle strobe from a bit clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stackPointerClear <= 1'b0;
    end else begin
      stackPointerClear <= ramAddr[1:0] == 2'h0 && clrMask[mmd_pkg::POS_SP_CLEAR];
    end
  end

  // control nibble $002
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl2 <= mmd_pkg::CTRL_RESET;
    end else if (ramAddr[1:0] == 2'h2) begin
      ctrl2 <= ((ctrl2 | setMask) & ~clrMask) | ev2;
    end else begin
      ctrl2 <= ctrl2 | ev2;
    end
  end

  // control nibble $003
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl3 <= mmd_pkg::CTRL_RESET;
    end else if (ramAddr[1:0] == 2'h3) begin
      ctrl3 <= ((ctrl3 | setMask) & ~clrMask) | ev3;
    end else begin
      ctrl3 <= ctrl3 | ev3;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bit test read-back; address $001 is unused and reads zero
  always_comb begin
    case (ramAddr[1:0])
      2'h0: nibble = ctrl0 & 4'hd; // stack clear reads zero
      2'h2: nibble = ctrl2;
      2'h3: nibble = ctrl3;
      default: nibble = 4'h0;
    endcase
  end

  // test result and its strobe, one cycle after the test
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      testBit <= 1'b0;
      testValid <= 1'b0;
    end else begin
      testValid <= tstOp;
      testBit <= tstOp && nibble[bitSel];
    end
  end

  // request toward the core
  // registered so the core sees one clean level per cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irqRequest <= 1'b0;
    end else begin
      irqRequest <= ctrl0[mmd_pkg::POS_GIE] &&
        ((ctrl0[mmd_pkg::POS_REQ_HI] && !ctrl0[mmd_pkg::POS_MASK_HI]) ||
         (ctrl2[mmd_pkg::POS_REQ_HI] && !ctrl2[mmd_pkg::POS_MASK_HI]) ||
         (ctrl2[mmd_pkg::POS_REQ_LO] && !ctrl2[mmd_pkg::POS_MASK_LO]) ||
         (ctrl3[mmd_pkg::POS_REQ_HI] && !ctrl3[mmd_pkg::POS_MASK_HI]) ||
         (ctrl3[mmd_pkg::POS_REQ_LO] && !ctrl3[mmd_pkg::POS_MASK_LO]));
    end
  end
endmodule

//--- bench/mmd_rom_model.sv
`timescale 1ns/1ns
////////////////////////////////////////
// rom contents seen by the fetch side: a fixed scramble of the address
module mmd_rom_model (
  input wire logic [13:0] romAddr,
  output logic [9:0] romData
);
  assign romData = romAddr[9:0] ^ 10'h2a5;
endmodule

//--- bench/mmd_memory_map_chk.sv
`timescale 1ns/1ns
////////////////////////////////////////
module mmd_memory_map_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [13:0] romAddr,
  input wire logic fetchValid,
  input wire logic isZeroPageCall,
  input wire logic isTableMove,
  input wire logic tableDestAccB,
  input wire logic [9:0] romData,
  input wire logic [2:0] vectorCause,
  input wire logic vectorTake,
  input wire logic romFault,
  input wire logic vectorRegion,
  input wire logic [13:0] vectorAddr,
  input wire logic [7:0] patternData,
  input wire logic patternToAccB,
  input wire logic [9:0] ramAddr,
  input wire logic [2:0] bitOp,
  input wire logic [1:0] bitSel,
  input wire logic selCtrl,
  input wire logic selSpecial,
  input wire logic selFlag,
  input wire logic selStorage,
  input wire logic ext0Event,
  input wire logic stackPointerClear,
  input wire logic irqRequest,
  input wire logic [3:0] ctrl0,
  input wire logic [3:0] ctrl2,
  input wire logic [3:0] ctrl3
);
  logic irqCond;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // enabled source with request set and mask clear
  assign irqCond = ctrl0[0] & ((ctrl0[2] & ~ctrl0[3]) | (ctrl2[2] & ~ctrl2[3]) |
    (ctrl2[0] & ~ctrl2[1]) | (ctrl3[2] & ~ctrl3[3]) | (ctrl3[0] & ~ctrl3[1]));
  sequence table_s;
    fetchValid && isTableMove && romAddr <= 14'h0fff;
  endsequence
  sequence bad_call_s;
    fetchValid && isZeroPageCall && romAddr > 14'h003f;
  endsequence
  AST_SEL_CTRL: assert property (selCtrl == (ramAddr <= 10'h003))
    else $error("control decode wrong");
  AST_VECTOR: assert property (
    vectorTake |=> vectorAddr == {10'h000, $past(vectorCause), 1'b0}) else $error("bad vector");
  AST_TABLE: assert property (table_s |=> patternToAccB == $past(tableDestAccB) &&
    {2'h0, patternData} == ($past(romData) & 10'h0ff)) else $error("bad pattern");
  AST_ZPAGE: assert property (bad_call_s |=> romFault) else $error("no call fault");
  AST_SET: assert property (
    bitOp == 3'h1 && ramAddr == 10'h002 && bitSel == 2'h3 |=> ctrl2[3]) else $error("set lost");
  AST_NOSET: assert property (bitOp == 3'h1 && ramAddr == 10'h000 && bitSel == 2'h2 &&
    !ctrl0[2] && !ext0Event |=> !ctrl0[2]) else $error("flag set by software");
  AST_STACK: assert property (bitOp == 3'h2 && ramAddr == 10'h000 && bitSel == 2'h1
    |=> stackPointerClear) else $error("no stack clear");
  AST_IRQ: assert property (irqRequest == $past(irqCond)) else $error("bad irq");
  AST_VREGION: assert property (
    vectorRegion == $past(fetchValid && romAddr <= 14'h000f)) else $error("vector window wrong");
  AST_FAULT: assert property (
    romFault == $past(fetchValid && ((isZeroPageCall && romAddr > 14'h003f) ||
    (isTableMove && romAddr > 14'h0fff)))) else $error("fault flag wrong");
  AST_DECODE: assert property (
    selFlag == (ramAddr >= 10'h020 && ramAddr <= 10'h023) &&
    selStorage == (ramAddr > 10'h03f) &&
    selSpecial == ((ramAddr >= 10'h004 && ramAddr <= 10'h01f) ||
    (ramAddr >= 10'h024 && ramAddr <= 10'h03f))) else $error("data decode wrong");
endmodule
bind mmd_memory_map mmd_memory_map_chk i_mmd_memory_map_chk (.*);

//--- bench/mmd_memory_map_tb_top.sv
`timescale 1ns/1ns
////////////////////////////////////////
module mmd_memory_map_tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic fetchValid = 1'b0, isZeroPageCall = 1'b0, isTableMove = 1'b0, tableDestAccB = 1'b0;
  logic vectorTake = 1'b0, ext0Event = 1'b0, timerBEvent = 1'b0, timerCEvent = 1'b0;
  logic serialEvent = 1'b0, adcEvent = 1'b0;
  logic [13:0] romAddr = '0, vectorAddr;
  logic [2:0] vectorCause = '0, bitOp = '0;
  logic [9:0] ramAddr = '0, romData;
  logic [1:0] bitSel = '0;
  logic romFault, vectorRegion, patternToPorts, patternToAccB, selCtrl, selSpecial, selFlag;
  logic selStorage, testBit, testValid, stackPointerClear, irqRequest;
  logic [7:0] patternData;
  logic [3:0] ctrl0, ctrl2, ctrl3;
  logic [3:0] c [4] = '{default: '0};
  logic tq[$];
  logic [9:0] pq[$];
  int errors = 0, checks = 0, cyc = 0;
  logic [31:0] rs = 32'h0000ff3f;

  mmd_rom_model i_mmd_rom_model (
    .romAddr(romAddr),
    .romData(romData)
  );
  mmd_memory_map i_mmd_memory_map (
    .ref_clk(ref_clk),
    .rst(rst),
    .romAddr(romAddr),
    .fetchValid(fetchValid),
    .isZeroPageCall(isZeroPageCall),
    .isTableMove(isTableMove),
    .tableDestAccB(tableDestAccB),
    .romData(romData),
    .vectorCause(vectorCause),
    .vectorTake(vectorTake),
    .romFault(romFault),
    .vectorRegion(vectorRegion),
    .vectorAddr(vectorAddr),
    .patternData(patternData),
    .patternToPorts(patternToPorts),
    .patternToAccB(patternToAccB),
    .ramAddr(ramAddr),
    .bitOp(bitOp),
    .bitSel(bitSel),
    .selCtrl(selCtrl),
    .selSpecial(selSpecial),
    .selFlag(selFlag),
    .selStorage(selStorage),
    .testBit(testBit),
    .testValid(testValid),
    .ext0Event(ext0Event),
    .timerBEvent(timerBEvent),
    .timerCEvent(timerCEvent),
    .serialEvent(serialEvent),
    .adcEvent(adcEvent),
    .stackPointerClear(stackPointerClear),
    .irqRequest(irqRequest),
    .ctrl0(ctrl0),
    .ctrl2(ctrl2),
    .ctrl3(ctrl3)
  );

  // clock
  always #20 ref_clk = ~ref_clk;

  function automatic void step();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
  endfunction

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic end_sim();
    if (errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // notes expected results and keeps a shadow of the control nibbles
  task automatic note();
    logic [1:0] a;
    a = ramAddr[1:0];
    if (isTableMove) pq.push_back({~tableDestAccB, tableDestAccB, romAddr[7:0] ^ 8'ha5});
    if (ramAddr <= 10'h003 && a != 2'h1) begin
      if (bitOp == 3'h3 && !(a == 2'h0 && bitSel == 2'h1)) tq.push_back(c[a][bitSel]);
      if (bitOp == 3'h2) c[a][bitSel] = 1'b0;
      if (bitOp == 3'h1 && (a == 2'h0 ? bitSel == 2'h3 || bitSel == 2'h0 : bitSel[0])) begin
        c[a][bitSel] = 1'b1;
      end
    end
    c[0][2] |= ext0Event;
    c[2][2] |= timerCEvent;
    c[2][0] |= timerBEvent;
    c[3][2] |= serialEvent;
    c[3][0] |= adcEvent;
  endtask

  // random traffic on both sides, driven at the falling edge
  initial begin
    repeat (6) @(posedge ref_clk);
    for (int i = 0; i < 600; i++) begin
      @(negedge ref_clk);
      rst = 1'b0;
      step();
      ramAddr = rs[0] ? {3'h0, rs[30], rs[6:1]} : {8'h00, rs[2:1]};
      bitSel = rs[8:7];
      bitOp = 3'(rs[12:9] % 5);
      // software never tests an unused bit or the stack clear bit
      if (bitOp == 3'h3 && ramAddr <= 10'h003 && (ramAddr[1:0] == 2'h1 ||
          (ramAddr[1:0] == 2'h0 && bitSel == 2'h1))) begin
        bitOp = 3'h0;
      end
      {ext0Event, timerBEvent, timerCEvent, serialEvent, adcEvent} = rs[15:13] == 0 ? rs[20:16] : '0;
      vectorTake = rs[21];
      vectorCause = rs[24:22];
      isTableMove = rs[25];
      isZeroPageCall = rs[26] & ~rs[25];
      fetchValid = rs[25] | rs[27];
      tableDestAccB = rs[28];
      romAddr = rs[29] ? {2'h0, rs[12:1]} : {8'h00, rs[6:1]};
      note();
    end
    @(negedge ref_clk);
    {bitOp, fetchValid, isTableMove, vectorTake} = '0;
    {ext0Event, timerBEvent, timerCEvent, serialEvent, adcEvent} = '0;
    repeat (2) @(negedge ref_clk);
    cmp({ctrl0, ctrl2, ctrl3}, {c[0], c[2], c[3]}, "nibbles");
    cmp(16'(tq.size() + pq.size()), 16'h0000, "left over");
    end_sim();
  end

  // takes the oldest note whenever a result shows
  always @(negedge ref_clk) begin
    if (testValid === 1'b1) cmp(testBit, tq.pop_front(), "bit test");
    if (patternToPorts === 1'b1 || patternToAccB === 1'b1) begin
      cmp({patternToPorts, patternToAccB, patternData}, pq.pop_front(), "pattern");
    end
  end

  // hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 1000) begin
      errors++;
      end_sim();
    end
  end
endmodule
